// >>> logic/accel_regs_pkg.sv
// Purpose: Shared constants for the power, interrupt and format register bank
// Assumes: Byte-wide register port, 125 MHz system clock
// Notes:   Offsets are the printed register addresses
package accel_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_MODE   = 8'h2D;
  localparam logic [7:0] ADDR_INT_ENABLE   = 8'h2E;
  localparam logic [7:0] ADDR_INT_PIN_SEL  = 8'h2F;
  localparam logic [7:0] ADDR_INT_FLAGS    = 8'h30;
  localparam logic [7:0] ADDR_OUT_FORMAT   = 8'h31;
  localparam logic [7:0] ADDR_AXIS_FIRST   = 8'h32;
  localparam logic [7:0] ADDR_AXIS_LAST    = 8'h37;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POWER_MODE    = 8'h00;
  localparam logic [7:0] RST_INT_ENABLE    = 8'h00;
  localparam logic [7:0] RST_INT_PIN_SEL   = 8'h00;
  localparam logic [7:0] RST_OUT_FORMAT    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PM_LINK      = 5;
  localparam int PM_AUTODOZE  = 4;
  localparam int PM_MEASURE   = 3;
  localparam int PM_SLEEP     = 2;
  localparam int PM_WAKE_HI   = 1;
  localparam int IRQ_READY    = 7;
  localparam int IRQ_TAP1     = 6;
  localparam int IRQ_TAP2     = 5;
  localparam int IRQ_MOTION   = 4;
  localparam int IRQ_STILL    = 3;
  localparam int IRQ_FALL     = 2;
  localparam int IRQ_WMARK    = 1;
  localparam int IRQ_OVERRUN  = 0;
  localparam int OF_SELFTEST  = 7;
  localparam int OF_SPI3      = 6;
  localparam int OF_INVERT    = 5;
  localparam int OF_FIXED     = 3;
  localparam int OF_JUSTIFY   = 2;
  localparam int OF_RANGE_HI  = 1;
  localparam logic [7:0] POWER_MODE_MASK = 8'h3F;
  localparam logic [7:0] OUT_FORMAT_MASK = 8'hEF;
  localparam logic [7:0] DATA_FLAG_MASK  = 8'h83;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ   = 125_000_000;
  localparam int SLEEP_HZ_MAX = 8;
  localparam int SLEEP_TICK_CYCLES = SYS_CLK_HZ / SLEEP_HZ_MAX;

endpackage : accel_regs_pkg

// >>> logic/accel_power_irq_format_regs.sv
// Purpose: Power mode, interrupt enable/routing/flags and output format registers
// Assumes: Host serial engine delivers byte-wide register strobes on clk_sys
// Notes:   Detectors and axis sampling live outside; this bank steers them
//          Sleep output, ready suppression and detector gating share one decode
//          so no output lags another by a cycle when sleep begins or ends
//          Asleep state is visible only at the outputs here, never through reg_rdata
`timescale 1ns/1ps

module accel_power_irq_format_regs
  import accel_regs_pkg::*;
#(
  parameter int SLEEP_TICK = SLEEP_TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] event_pulse,
  input  wire logic       data_drained,
  input  wire logic       motion_seen,
  input  wire logic       still_seen,
  output logic            measure_on,
  output logic            sleeping,
  output logic            motion_run,
  output logic            still_run,
  output logic            others_run,
  output logic            fifo_write_en,
  output logic            sample_tick_sleep,
  output logic            sample_use_wake,
  output logic            self_test_force,
  output logic            spi_three_wire,
  output logic            fixed_scale_resolution,
  output logic            justify_left,
  output logic      [1:0] range_sel,
  output logic            clip_en,
  output logic            irq_pin_a,
  output logic            irq_pin_b
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Shadow registers behind the five offsets
  logic [7:0]  power_mode_control_reg;
  logic [7:0]  interrupt_enable_mask_reg;
  logic [7:0]  interrupt_pin_select_reg;
  logic [7:0]  interrupt_flags_reg;
  logic [7:0]  interrupt_flags_next;
  logic [7:0]  output_format_control_reg;
  logic        asleep_reg;
  logic        asleep_next;
  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_limit;

  // Link chain phases, one-hot
  typedef enum logic [1:0] {
    LINK_WAIT_STILL  = 2'b01,
    LINK_WAIT_MOTION = 2'b10
  } link_state_t;
  link_state_t link_state_reg;

  logic link_on;
  logic doze_on;
  logic wr_hit_pm;
  logic rd_flags;
  logic rd_axis;
  logic [7:0] active_irq;
  logic       sleep_now;

  // ----------------------------------------------------------------
  // Strobe decodes
  // ----------------------------------------------------------------
  // Decode a write to one offset
  function automatic logic wr_at(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction : wr_at

  // Decode a read of one offset
  function automatic logic rd_at(input logic [7:0] a);
    return reg_rd && (reg_addr == a);
  endfunction : rd_at

  // Level of one pin: enabled sources routed there, ORed, then polarity
  function automatic logic pin_level(input logic [7:0] act, input logic [7:0] route,
                                     input logic inv);
    return (|(act & route)) ^ inv;
  endfunction : pin_level

  // Register decodes; sleep_now is the one sleep source for every output
  assign link_on   = power_mode_control_reg[PM_LINK];
  assign doze_on   = link_on && power_mode_control_reg[PM_AUTODOZE];
  assign wr_hit_pm = wr_at(ADDR_POWER_MODE);
  assign rd_flags  = rd_at(ADDR_INT_FLAGS);
  assign rd_axis   = reg_rd && (reg_addr >= ADDR_AXIS_FIRST) && (reg_addr <= ADDR_AXIS_LAST);
  assign sleep_now = power_mode_control_reg[PM_SLEEP] || asleep_reg;

  // ----------------------------------------------------------------
  // Writable registers; reserved bits stay zero
  // ----------------------------------------------------------------
  // Flag register is read-only, so a write to its offset falls through
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      power_mode_control_reg    <= RST_POWER_MODE;  // Standby at power-up
      interrupt_enable_mask_reg <= RST_INT_ENABLE;
      interrupt_pin_select_reg  <= RST_INT_PIN_SEL;
      output_format_control_reg <= RST_OUT_FORMAT;
    end else begin
      if (wr_hit_pm) begin
        power_mode_control_reg <= reg_wdata & POWER_MODE_MASK;
      end
      if (wr_at(ADDR_INT_ENABLE)) begin
        interrupt_enable_mask_reg <= reg_wdata;
      end
      if (wr_at(ADDR_INT_PIN_SEL)) begin
        interrupt_pin_select_reg <= reg_wdata;
      end
      if (wr_at(ADDR_OUT_FORMAT)) begin
        output_format_control_reg <= reg_wdata & OUT_FORMAT_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link sequencing of motion and stillness detection
  // ----------------------------------------------------------------
  // Any power write restarts the chain so a stale phase never survives
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      link_state_reg <= LINK_WAIT_STILL;
    end else if (wr_hit_pm || !power_mode_control_reg[PM_MEASURE]) begin
      link_state_reg <= LINK_WAIT_STILL;
    end else begin
      case (link_state_reg)
        LINK_WAIT_STILL: begin
          if (still_seen && link_on) link_state_reg <= LINK_WAIT_MOTION;
        end
        LINK_WAIT_MOTION: begin
          if (motion_seen && link_on) link_state_reg <= LINK_WAIT_STILL;
        end
        default: link_state_reg <= LINK_WAIT_STILL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Automatic sleep status
  // ----------------------------------------------------------------
  // Held unless auto-doze is configured, so manual sleep leaves it alone
  always_comb begin
    asleep_next = asleep_reg;
    if (!doze_on) begin
      asleep_next = asleep_reg;
    end else if (still_seen && link_state_reg == LINK_WAIT_STILL) begin
      asleep_next = 1'b1;
    end else if (motion_seen && link_state_reg == LINK_WAIT_MOTION) begin
      asleep_next = 1'b0;  // Back to normal rate
    end
  end

  // Standby forgets automatic sleep so measurement restarts awake
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      asleep_reg <= 1'b0;
    end else if (!power_mode_control_reg[PM_MEASURE]) begin
      asleep_reg <= 1'b0;
    end else begin
      asleep_reg <= asleep_next;
    end
  end

  // ----------------------------------------------------------------
  // Sleep-rate divider: base 8 Hz tick scaled by the wake bits
  // ----------------------------------------------------------------
  // Slower wake codes stretch the same base period; no second divider
  always_comb begin
    case (power_mode_control_reg[PM_WAKE_HI -: 2])
      2'b00:   tick_limit = SLEEP_TICK;  // 8 Hz
      2'b01:   tick_limit = SLEEP_TICK * 2;  // 4 Hz
      2'b10:   tick_limit = SLEEP_TICK * 4;  // 2 Hz
      default: tick_limit = SLEEP_TICK * 8;  // 1 Hz
    endcase
  end

  // Counter runs only while asleep; one-cycle tick per wake period
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg      <= 32'h0000_0000;
      sample_tick_sleep <= 1'b0;
    end else if (!(power_mode_control_reg[PM_SLEEP] || asleep_reg)) begin
      tick_cnt_reg      <= 32'h0000_0000;
      sample_tick_sleep <= 1'b0;
    end else if (tick_cnt_reg >= tick_limit - 32'h0000_0001) begin
      tick_cnt_reg      <= 32'h0000_0000;
      sample_tick_sleep <= 1'b1;  // Axis outputs still refresh
    end else begin
      tick_cnt_reg      <= tick_cnt_reg + 32'h0000_0001;
      sample_tick_sleep <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt source flags; a new event wins over a clearing read
  // ----------------------------------------------------------------
  // Clearing reads first, then events OR in so a same-cycle event survives
  always_comb begin
    interrupt_flags_next = interrupt_flags_reg;
    if (rd_axis && data_drained) begin
      interrupt_flags_next = interrupt_flags_next & ~DATA_FLAG_MASK;
    end
    if (rd_flags) begin
      interrupt_flags_next = interrupt_flags_next & DATA_FLAG_MASK;
    end
    // Ready is held back while sleeping; data flags ignore enables
    interrupt_flags_next = interrupt_flags_next | (event_pulse & ~(sleep_now ?
                           (8'h01 << IRQ_READY) : 8'h00));
  end

  // Plain register; all set and clear terms live in the decode above
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      interrupt_flags_reg <= 8'h00;
    end else begin
      interrupt_flags_reg <= interrupt_flags_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pins
  // ----------------------------------------------------------------
  // Enable gates only the pins; flags were set regardless above
  assign active_irq = interrupt_flags_next & interrupt_enable_mask_reg;

  // Pins follow the next flag value so a flag and its pin move together
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_pin_a <= 1'b0;
      irq_pin_b <= 1'b0;
    end else begin
      irq_pin_a <= pin_level(active_irq, ~interrupt_pin_select_reg,
                             output_format_control_reg[OF_INVERT]);
      irq_pin_b <= pin_level(active_irq, interrupt_pin_select_reg,
                             output_format_control_reg[OF_INVERT]);
    end
  end

  // ----------------------------------------------------------------
  // Power-side outputs to sensor and detectors
  // ----------------------------------------------------------------
  // Registered so every top output comes straight from a flip-flop; the sleep-gated ones read
  // sleep_now, never the registered sleeping, so the gating lines up with it
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      measure_on      <= 1'b0;
      sleeping        <= 1'b0;
      motion_run      <= 1'b0;
      still_run       <= 1'b0;
      others_run      <= 1'b0;
      fifo_write_en   <= 1'b0;
      sample_use_wake <= 1'b0;
    end else begin
      measure_on      <= power_mode_control_reg[PM_MEASURE];
      sleeping        <= sleep_now;
      motion_run      <= power_mode_control_reg[PM_MEASURE]
                         && (!link_on || link_state_reg == LINK_WAIT_MOTION);
      still_run       <= power_mode_control_reg[PM_MEASURE] && !sleep_now
                         && (!link_on || link_state_reg == LINK_WAIT_STILL);
      others_run      <= power_mode_control_reg[PM_MEASURE] && !sleep_now;
      fifo_write_en   <= power_mode_control_reg[PM_MEASURE] && !sleep_now;
      sample_use_wake <= sleep_now;
    end
  end

  // ----------------------------------------------------------------
  // Format-side outputs to sensor, data path and serial engine
  // ----------------------------------------------------------------
  // Copies of the format register plus the clip_en range decode, two cycles behind a write strobe
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      self_test_force        <= 1'b0;
      spi_three_wire         <= 1'b0;
      fixed_scale_resolution <= 1'b0;
      justify_left           <= 1'b0;
      range_sel              <= 2'b00;
      clip_en                <= 1'b1;
    end else begin
      self_test_force        <= output_format_control_reg[OF_SELFTEST];
      spi_three_wire         <= output_format_control_reg[OF_SPI3];
      fixed_scale_resolution <= output_format_control_reg[OF_FIXED];
      justify_left           <= output_format_control_reg[OF_JUSTIFY];
      range_sel              <= output_format_control_reg[OF_RANGE_HI -: 2];
      clip_en                <= output_format_control_reg[OF_RANGE_HI -: 2] != 2'b11;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered one cycle after the read strobe
  // ----------------------------------------------------------------
  // Data stands until the next read; axis offsets read zero here
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_POWER_MODE:  reg_rdata <= power_mode_control_reg;
        ADDR_INT_ENABLE:  reg_rdata <= interrupt_enable_mask_reg;
        ADDR_INT_PIN_SEL: reg_rdata <= interrupt_pin_select_reg;
        ADDR_INT_FLAGS:   reg_rdata <= interrupt_flags_reg;
        ADDR_OUT_FORMAT:  reg_rdata <= output_format_control_reg;
        default:          reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : accel_power_irq_format_regs

// >>> bench/accel_detect_model.sv
// Purpose: Detector-side stand-in that feeds event pulses to the bank
// Assumes: Pulses launched 1 ns after a clk_sys edge, one cycle wide
// Notes:   Fires whatever the enable register says; gating is the bank's job
`timescale 1ns/1ps

module accel_detect_model (
  input  wire logic       clk_sys,
  output logic      [7:0] event_pulse,
  output logic            motion_seen,
  output logic            still_seen,
  output logic            data_drained
);
  // Idle: no events, FIFO empty so one axis read drains it
  initial begin
    event_pulse  = 8'h00;
    motion_seen  = 1'b0;
    still_seen   = 1'b0;
    data_drained = 1'b1;
  end

  // One-cycle pulse regardless of enables
  task automatic pulse(input logic [7:0] ev, input logic mo, input logic st);
    event_pulse = ev;
    motion_seen = mo;
    still_seen  = st;
    @(posedge clk_sys);
    #1;
    event_pulse = 8'h00;
    motion_seen = 1'b0;
    still_seen  = 1'b0;
  endtask : pulse

  // Level the bench flips to model a partly drained FIFO
  task automatic set_drained(input logic lv);
    data_drained = lv;
  endtask : set_drained
endmodule : accel_detect_model

// >>> bench/accel_power_irq_format_regs_asserts.sv
// Purpose: Port-level checks for the power, interrupt and format bank
// Assumes: Strobes and detector pulses sampled on clk_sys
// Notes:   Bound into the bank; watches its ports only
`timescale 1ns/1ps

module accel_power_irq_format_regs_asserts
  import accel_regs_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] event_pulse,
  input wire logic       measure_on,
  input wire logic       sleeping,
  input wire logic       motion_run,
  input wire logic       still_run,
  input wire logic       others_run,
  input wire logic       fifo_write_en,
  input wire logic       sample_tick_sleep,
  input wire logic       sample_use_wake,
  input wire logic       self_test_force,
  input wire logic       spi_three_wire,
  input wire logic       fixed_scale_resolution,
  input wire logic       justify_left,
  input wire logic [1:0] range_sel,
  input wire logic       clip_en,
  input wire logic       irq_pin_a,
  input wire logic       irq_pin_b
);
  // Strobe decodes; a second write right behind would retarget outputs
  logic pm_wr;
  logic of_wr;
  logic fl_rd;
  assign pm_wr = reg_wr && reg_addr == ADDR_POWER_MODE;
  assign of_wr = reg_wr && reg_addr == ADDR_OUT_FORMAT;
  assign fl_rd = reg_rd && reg_addr == ADDR_INT_FLAGS;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_measure_follows: assert property (pm_wr ##1 !pm_wr |=>
    measure_on == $past(reg_wdata[PM_MEASURE], 2)) else $error("measure output stale");
  a_format_follows: assert property (of_wr ##1 !of_wr |=>
    {self_test_force, spi_three_wire, fixed_scale_resolution, justify_left, range_sel}
    == {$past(reg_wdata[7:6], 2), $past(reg_wdata[3:0], 2)}) else $error("format outputs stale");
  a_clip_range: assert property (clip_en == (range_sel != 2'b11))
    else $error("clip does not match range");
  a_sleep_quiet: assert property (sleeping |->
    !fifo_write_en && !others_run && !still_run) else $error("work continues in sleep");
  a_standby_idle: assert property (!measure_on |-> !motion_run && !still_run)
    else $error("detector runs in standby");
  a_power_reserved: assert property (reg_rd && reg_addr == ADDR_POWER_MODE |=>
    reg_rdata[7:6] == 2'b00) else $error("reserved power bits set");
  a_flags_clear: assert property (fl_rd && event_pulse == 8'h00 ##1 event_pulse == 8'h00
    ##1 fl_rd |=> reg_rdata[6:2] == 5'h00) else $error("flags survive a flag read");
  a_tick_wake: assert property (sample_tick_sleep |-> sample_use_wake)
    else $error("sleep tick without wake rate");

  c_sleep_entry: cover property ($rose(sleeping));
  c_pin_a: cover property ($rose(irq_pin_a));
  c_pin_b: cover property ($rose(irq_pin_b));
endmodule : accel_power_irq_format_regs_asserts

bind accel_power_irq_format_regs accel_power_irq_format_regs_asserts chk (.*);

// >>> bench/accel_power_irq_format_regs_test.sv
// Purpose: Register, interrupt and sleep scenarios for the bank
// Assumes: Inputs change 1 ns after the rising edge; short sleep tick
// Notes:   Every wait is bounded and counts as a mismatch when it runs out
`timescale 1ns/1ps

module accel_power_irq_format_regs_test;
  import accel_regs_pkg::*;
  localparam int TICK = 10;
  logic       clk_sys, nrst, reg_wr, reg_rd, data_drained, motion_seen, still_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, event_pulse, seen;
  logic       measure_on, sleeping, motion_run, still_run, others_run, fifo_write_en;
  logic       sample_tick_sleep, sample_use_wake, self_test_force, spi_three_wire;
  logic       fixed_scale_resolution, justify_left, clip_en, irq_pin_a, irq_pin_b;
  logic [1:0] range_sel;
  int         n_errors = 0, n_compared = 0, k, w;

  accel_power_irq_format_regs #(.SLEEP_TICK(TICK)) dut (.*);
  accel_detect_model det (.clk_sys(clk_sys), .event_pulse(event_pulse),
    .motion_seen(motion_seen), .still_seen(still_seen), .data_drained(data_drained));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Extra edge at the end lets control outputs catch up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    step();
    reg_wr = 1'b0;
    step();
    step();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_rd   = 1'b1;
    reg_addr = a;
    step();
    reg_rd = 1'b0;
    seen   = reg_rdata;
    step();
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk("read", exp, seen);
  endtask : rc
  task automatic await(ref logic s, input logic v);
    for (int i = 0; i < 200 && s !== v; i++) step();
    chk("wait", {7'h00, v}, {7'h00, s});
    if (s !== v) test_done();
  endtask : await
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    nrst     = 1'b0;
    reg_wr   = 1'b0;
    reg_rd   = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    for (k = 8'h2D; k <= 8'h31; k++) rc(8'(k), 8'h00);
    chk("measure", 8'h00, {7'h00, measure_on});
    wr(ADDR_POWER_MODE, 8'hFF);
    rc(ADDR_POWER_MODE, POWER_MODE_MASK);
    wr(ADDR_POWER_MODE, 8'h00);
    wr(ADDR_INT_FLAGS, 8'hFF);
    rc(ADDR_INT_FLAGS, 8'h00);
    wr(8'h50, 8'h5A);
    rc(8'h50, 8'h00);
    // Every range code, then all format bits with the pins inverted
    for (k = 0; k < 4; k++) begin
      wr(ADDR_OUT_FORMAT, 8'(k));
      chk("range", 8'(k), {6'h00, range_sel});
      chk("clip", {7'h00, k != 3}, {7'h00, clip_en});
    end
    wr(ADDR_OUT_FORMAT, 8'hFF);
    rc(ADDR_OUT_FORMAT, OUT_FORMAT_MASK);
    chk("fmt", 8'h0F, {4'h0, self_test_force, spi_three_wire, fixed_scale_resolution,
      justify_left});
    chk("idle inv", 8'h03, {6'h00, irq_pin_a, irq_pin_b});
    wr(ADDR_OUT_FORMAT, 8'h00);
    // Map before enable; each source alone lands on its mapped pin
    wr(ADDR_INT_PIN_SEL, 8'h0F);
    for (k = 0; k < 8; k++) begin
      wr(ADDR_INT_ENABLE, 8'(1 << k));
      det.pulse(8'hFF, 1'b0, 1'b0);
      chk("pins", {6'h00, k > 3, k < 4}, {6'h00, irq_pin_a, irq_pin_b});
      rd(ADDR_INT_FLAGS);
      rd(ADDR_AXIS_FIRST);
    end
    wr(ADDR_INT_ENABLE, 8'h42);
    det.pulse(8'h42, 1'b0, 1'b0);
    chk("pins", 8'h03, {6'h00, irq_pin_a, irq_pin_b});
    det.set_drained(1'b0);
    rc(ADDR_INT_FLAGS, 8'h42);
    chk("pins", 8'h01, {6'h00, irq_pin_a, irq_pin_b});
    rc(ADDR_INT_FLAGS, 8'h02);
    rd(ADDR_AXIS_FIRST);
    rc(ADDR_INT_FLAGS, 8'h02);
    det.set_drained(1'b1);
    rd(ADDR_AXIS_LAST);
    rc(ADDR_INT_FLAGS, 8'h00);
    wr(ADDR_INT_ENABLE, 8'h00);
    det.pulse(8'h01, 1'b0, 1'b0);
    chk("pins", 8'h00, {6'h00, irq_pin_a, irq_pin_b});
    rc(ADDR_INT_FLAGS, 8'h01);
    rd(ADDR_AXIS_FIRST);
    // Linked auto-doze at every wake rate
    wr(ADDR_INT_ENABLE, 8'hFF);
    for (w = 0; w < 4; w++) begin
      wr(ADDR_POWER_MODE, 8'h38 | 8'(w));
      chk("measure", 8'h01, {7'h00, measure_on});
      det.pulse(8'h00, 1'b0, 1'b1);
      await(sleeping, 1'b1);
      chk("motion run", 8'h01, {7'h00, motion_run});
      chk("still run", 8'h00, {7'h00, still_run});
      det.pulse(8'h80, 1'b0, 1'b0);
      rd(ADDR_INT_FLAGS);
      chk("ready", 8'h00, seen & 8'h80);
      await(sample_tick_sleep, 1'b1);
      step();
      for (k = 1; k < 200 && sample_tick_sleep !== 1'b1; k++) step();
      chk("period", 8'(TICK << w), 8'(k));
      det.pulse(8'h00, 1'b1, 1'b0);
      await(sleeping, 1'b0);
      wr(ADDR_POWER_MODE, 8'h00);
    end
    wr(ADDR_POWER_MODE, 8'h18);
    det.pulse(8'h00, 1'b0, 1'b1);
    repeat (4) step();
    chk("unlinked", 8'h00, {7'h00, sleeping});
    test_done();
  end
endmodule : accel_power_irq_format_regs_test
